/* src/adsc_clk_div.sv */
module adsc_clk_div
  import adsc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       use_rc,
  input  wire logic       rc_tick,
  input  wire logic [7:0] divider,
  output logic            tick
);
  logic [7:0] cnt;
  logic [7:0] div_eff;

  // Reserved divider codes saturate at the longest legal period
  assign div_eff = (divider > DIV_MAX) ? DIV_MAX : divider; // R5

  always_ff @(posedge core_clk) begin
    if (rst || !enable) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (use_rc) begin
      cnt  <= 8'h00;
      tick <= rc_tick; // R2
    end else if (cnt >= div_eff) begin
      cnt  <= 8'h00;
      tick <= 1'b1; // R5
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  a_tick_rc_follow : assert property (@(posedge core_clk) disable iff (rst)
    enable && $past(enable) && use_rc && $past(use_rc) |-> tick == $past(rc_tick)) // R2
    else $error("RC tick not followed");
  a_tick_sys_gap : assert property (@(posedge core_clk) disable iff (rst)
    tick && !use_rc && divider == 8'h01 && $past(divider) == 8'h01 && enable ##1
    enable && !use_rc && divider == 8'h01 |-> !tick) // R5
    else $error("Divided tick too fast");
endmodule

/* src/adsc_ctrl.sv */
// Operation
// [R1] Alternate bit set toggles input set A and B per sample, else set A.
// [R2] Clock source bit picks RC clock when set, system-derived clock when clear.
// [R3] Extended sampling flag reads 1 while sampling continues after sample enable clears.
// [R4] Auto-sample time field gives sampling length in conversion clock periods, 0 to 31.
// [R5] Divider field gives period of value plus one cycles; codes above 63 reserved.
// [R6] Software clears auto-scan when trigger picks the internal sample counter.
// [R7] Band-gap request enables band gap while converter is on and active.
// [R8] Write mode 10 discards results and interrupts only on a valid match.
// [R9] Write mode 01 stores a result only on match; mode 11 reserved.
// [R10] Compare modes 11 and 10 match outside or inside the threshold pair window.
// [R11] Compare mode 01 matches above threshold, mode 00 below threshold.
// [R12] Compare mode 11 sets hit flag on buffer write or on match.
// [R13] Other compare modes set hit flag only on match.
// [R14] Hit flags 0-15 in low word, 16-17 in bits 1-0 of high word.
// [R15] Upper scan word bits 14-10 are channels 30-26, bits 1-0 channels 17-16.
// [R16] Select and flag bits of unimplemented channels read zero.
// [R17] Software never picks unimplemented channels; results would be indeterminate.
// [R18] Band-gap input is 2x or 4x band gap following upper reference config bit; code picks 4x only when both config bits are 11.
// [R19] Each set has 3-bit negative select and 5-bit positive select.
// [R20] Buffer writes while converter is off program channel thresholds.
module adsc_ctrl
  import adsc_pkg::*;
#(
  parameter int NCH = 18
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        adc_on,
  input  wire logic        sample_enable_bit,
  input  wire logic        alternate_sample_sel,
  input  wire logic [1:0]  positive_ref_config,
  input  wire logic [15:0] scan_select_low,
  input  wire logic        rc_tick,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  output logic             conv_start,
  output logic      [4:0]  pos_input_sel,
  output logic      [2:0]  neg_input_sel,
  output logic             bandgap_enable,
  output logic             bandgap_x4,
  output logic             result_wr,
  output logic      [4:0]  result_addr,
  output logic      [11:0] result_data,
  output logic             compare_irq
);
  if (NCH < 18 || NCH > 26) begin : g_bad_nch
    $error("NCH must lie between 18 and 26");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_EXTEND, ST_CONVERT} adsc_state_e;

  logic [15:0] timing;
  logic [15:0] thresh_ctl;
  logic [15:0] sample_enable_bit_sel;
  logic [17:0] hit;
  logic [15:0] scan_high;
  logic [11:0] thr [32];
  adsc_state_e state;
  logic        use_b;
  logic [4:0]  scan_ch;
  logic [4:0]  scan_pos;
  logic [4:0]  ext_cnt;
  logic        tick;
  logic        extended_sampling_flag;
  logic [31:0] scan_mask;
  logic [31:0] impl_mask;
  logic [4:0]  cur_ch;
  logic        match;
  logic        hit_set_any;

  logic       conv_clock_source;
  logic [4:0] auto_sample_time;
  logic [7:0] conv_clock_divider;
  logic       auto_scan_enable;
  logic       bandgap_request;
  logic [1:0] scan_interrupt_mode;
  adsc_wm_e   write_mode;
  adsc_cm_e   compare_mode;

  assign conv_clock_source   = timing[TM_SRC_BIT];
  assign auto_sample_time    = timing[TM_AST_LSB +: 5];
  assign conv_clock_divider  = timing[TM_DIV_LSB +: 8];
  assign auto_scan_enable    = thresh_ctl[TS_SCAN_BIT];
  assign bandgap_request     = thresh_ctl[TS_BG_BIT];
  assign scan_interrupt_mode = thresh_ctl[TS_INT_LSB +: 2];
  assign write_mode          = adsc_wm_e'(thresh_ctl[TS_WM_LSB +: 2]);
  assign compare_mode        = adsc_cm_e'(thresh_ctl[TS_CM_LSB +: 2]);

  // Channels present on this device: pins 0..NCH-1 and internal sources 26..30
  always_comb begin
    impl_mask = 32'h7c00_0000;
    for (int i = 0; i < NCH; i++) begin
      impl_mask[i] = 1'b1;
    end
  end

  assign scan_mask = {scan_high[15:0], scan_select_low} & impl_mask; // R16

  function automatic logic [4:0] next_scan(input logic [31:0] mask, input logic [4:0] cur);
    logic [4:0] res;
    logic       found;
    logic [4:0] idx;
    res   = cur;
    found = 1'b0;
    for (int k = 1; k <= 32; k++) begin
      idx = 5'(cur + 5'(k));
      if (!found && mask[idx]) begin
        res   = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // An excluded scan position is skipped unless no channel is selected, so reset position 0 needs no select
  assign scan_pos = scan_mask[scan_ch] ? scan_ch : next_scan(scan_mask, scan_ch); // R15

  function automatic logic is_buf(input logic [5:0] a);
    return a >= BUF_BASE;
  endfunction

  adsc_clk_div u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .enable   (adc_on),
    .use_rc   (conv_clock_source),
    .rc_tick  (rc_tick),
    .divider  (conv_clock_divider),
    .tick     (tick)
  );

  // Scan overrides set A and set B for the positive input only
  always_comb begin
    if (auto_scan_enable) begin
      cur_ch = scan_pos; // R15
    end else if (use_b && alternate_sample_sel) begin
      cur_ch = sample_enable_bit_sel[SS_PB_LSB +: 5]; // R1
    end else begin
      cur_ch = sample_enable_bit_sel[SS_PA_LSB +: 5]; // R19
    end
  end

  always_comb begin
    case (compare_mode)
      CM_LESS:    match = conv_result < thr[cur_ch]; // R11
      CM_GREATER: match = conv_result > thr[cur_ch]; // R11
      CM_INSIDE:  match = conv_result >= thr[{cur_ch[4:1], 1'b0}] &&
                          conv_result <= thr[{cur_ch[4:1], 1'b1}]; // R10
      CM_OUTSIDE: match = conv_result < thr[{cur_ch[4:1], 1'b0}] ||
                          conv_result > thr[{cur_ch[4:1], 1'b1}]; // R10
      default:    match = 1'b0;
    endcase
  end

  logic done_ev;
  logic store;
  assign done_ev = state == ST_CONVERT && conv_done && adc_on;
  assign store   = write_mode == WM_SAVE_ALL ||
                   (write_mode == WM_SAVE_MATCH && match); // R9
  // Mode 11 flags a written buffer as well as a match
  assign hit_set_any = match || (compare_mode == CM_OUTSIDE && store); // R12 R13

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state   <= ST_IDLE;
      ext_cnt <= 5'h00;
    end else if (!adc_on) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:    if (sample_enable_bit) state <= ST_SAMPLE;
        ST_SAMPLE: begin
          if (!sample_enable_bit) begin
            ext_cnt <= auto_sample_time; // R4
            state   <= (auto_sample_time == 5'h00) ? ST_CONVERT : ST_EXTEND;
          end
        end
        ST_EXTEND: begin
          if (tick) begin
            ext_cnt <= ext_cnt - 5'h01;
            if (ext_cnt == 5'h01) state <= ST_CONVERT; // R4
          end
        end
        ST_CONVERT: if (conv_done) state <= ST_IDLE;
        default:    state <= ST_IDLE;
      endcase
    end
  end

  assign extended_sampling_flag = state == ST_EXTEND; // R3

  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= adc_on && state != ST_CONVERT && state != ST_IDLE &&
                    ((state == ST_SAMPLE && !sample_enable_bit && auto_sample_time == 5'h00) ||
                     (state == ST_EXTEND && tick && ext_cnt == 5'h01));
    end
  end

  // Input set and scan position advance once per finished conversion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      use_b   <= 1'b0;
      scan_ch <= 5'h00;
    end else if (done_ev) begin
      use_b   <= alternate_sample_sel && !use_b; // R1
      scan_ch <= next_scan(scan_mask, scan_pos); // R15
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos_input_sel  <= 5'h00;
      neg_input_sel  <= 3'h0;
      bandgap_enable <= 1'b0;
      bandgap_x4     <= 1'b0;
    end else begin
      pos_input_sel  <= cur_ch;
      neg_input_sel  <= (use_b && alternate_sample_sel) ? sample_enable_bit_sel[SS_NB_LSB +: 3]
                                                        : sample_enable_bit_sel[SS_NA_LSB +: 3]; // R19
      bandgap_enable <= bandgap_request && adc_on && state != ST_IDLE; // R7
      bandgap_x4     <= positive_ref_config == PV_2X_4X; // R18
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_wr   <= 1'b0;
      result_addr <= 5'h00;
      result_data <= 12'h000;
      compare_irq <= 1'b0;
    end else begin
      result_wr   <= done_ev && store; // R8 R9
      result_addr <= cur_ch;
      result_data <= conv_result;
      if (write_mode == WM_COMPARE_ONLY) begin
        compare_irq <= done_ev && match && scan_interrupt_mode != 2'b00; // R8
      end else begin
        compare_irq <= done_ev;
      end
    end
  end

  // Thresholds only take writes while the converter is off
  always_ff @(posedge core_clk) begin
    if (reg_wr && is_buf(reg_addr) && !adc_on && reg_addr[4:0] < 5'(NCH)) begin
      thr[reg_addr[4:0]] <= reg_wdata[11:0]; // R20
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timing     <= RST_TIMING;
      thresh_ctl <= RST_THRESH;
      sample_enable_bit_sel   <= RST_SAMPSEL;
      scan_high  <= RST_SCAN_HIGH;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_TIMING:    timing     <= reg_wdata & TM_WMASK;
        REG_THRESH:    thresh_ctl <= reg_wdata & TS_WMASK;
        REG_SAMPSEL:   sample_enable_bit_sel   <= reg_wdata;
        REG_SCAN_HIGH: scan_high  <= reg_wdata & SCAN_HIGH_MASK & impl_mask[31:16]; // R15 R16
        default:       ;
      endcase
    end
  end

  // A hit in the cycle of a software write survives it
  for (genvar c = 0; c < 18; c++) begin : g_hit
    logic sw_wr;
    logic sw_val;
    assign sw_wr  = reg_wr && reg_addr == ((c < 16) ? REG_HIT_LOW : REG_HIT_HIGH);
    assign sw_val = reg_wdata[c % 16];
    always_ff @(posedge core_clk) begin
      if (rst || c >= NCH) begin
        hit[c] <= 1'b0; // R16
      end else if (done_ev && hit_set_any && cur_ch == 5'(c)) begin
        hit[c] <= 1'b1; // R12 R13
      end else if (sw_wr) begin
        hit[c] <= sw_val;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (is_buf(reg_addr)) begin
      reg_rdata <= {4'h0, thr[reg_addr[4:0]]};
    end else begin
      case (reg_addr)
        REG_TIMING:    reg_rdata <= (timing & TM_WMASK) |
                                    (16'(extended_sampling_flag) << TM_EXT_BIT); // R3
        REG_THRESH:    reg_rdata <= thresh_ctl;
        REG_SAMPSEL:   reg_rdata <= sample_enable_bit_sel;
        REG_HIT_LOW:   reg_rdata <= hit[15:0]; // R14
        REG_HIT_HIGH:  reg_rdata <= {14'h0000, hit[17:16]} & HIT_HIGH_MASK; // R14
        REG_SCAN_HIGH: reg_rdata <= scan_high;
        default:       reg_rdata <= 16'h0000;
      endcase
    end
  end

  a_alt_toggle : assert property (@(posedge core_clk) disable iff (rst)
    done_ev && alternate_sample_sel |=> use_b != $past(use_b)) // R1
    else $error("Alternate set did not toggle");
  a_no_alt_seta : assert property (@(posedge core_clk) disable iff (rst)
    !alternate_sample_sel && !auto_scan_enable |-> cur_ch == sample_enable_bit_sel[4:0]) // R1
    else $error("Set A not used");
  a_ext_flag_src : assert property (@(posedge core_clk) disable iff (rst)
    state == ST_SAMPLE && !sample_enable_bit && adc_on && auto_sample_time != 5'h00
    |=> extended_sampling_flag) // R3
    else $error("Extended sampling flag missing");
  a_ext_len : assert property (@(posedge core_clk) disable iff (rst)
    state == ST_EXTEND && tick && ext_cnt == 5'h01 && adc_on |=> conv_start) // R4
    else $error("Sampling did not end on count");
  a_bg_off : assert property (@(posedge core_clk) disable iff (rst)
    !bandgap_request |=> !bandgap_enable) // R7
    else $error("Band gap enabled without request");
  a_wm_compare : assert property (@(posedge core_clk) disable iff (rst)
    write_mode == WM_COMPARE_ONLY |=> !result_wr) // R8
    else $error("Result stored in compare-only mode");
  a_irq_match : assert property (@(posedge core_clk) disable iff (rst)
    write_mode == WM_COMPARE_ONLY && done_ev && !match |=> !compare_irq) // R8
    else $error("Interrupt without match");
  a_save_match : assert property (@(posedge core_clk) disable iff (rst)
    write_mode == WM_SAVE_MATCH && done_ev |=> result_wr == $past(match)) // R9
    else $error("Save-on-match wrong");
  a_hit_set : assert property (@(posedge core_clk) disable iff (rst)
    done_ev && match && cur_ch < 5'(NCH) && cur_ch < 5'd18 |=> hit[$past(cur_ch)]) // R13
    else $error("Hit flag not set");
  a_hit_high_zero : assert property (@(posedge core_clk) disable iff (rst)
    reg_addr == REG_HIT_HIGH |=> reg_rdata[15:2] == 14'h0000) // R14
    else $error("Hit high upper bits nonzero");
  a_scan_high_zero : assert property (@(posedge core_clk) disable iff (rst)
    reg_addr == REG_SCAN_HIGH |=> (reg_rdata & ~SCAN_HIGH_MASK) == 16'h0000) // R16
    else $error("Unimplemented scan bits nonzero");

  c_extend : cover property (@(posedge core_clk) state == ST_EXTEND ##1 conv_start);
  c_alt : cover property (@(posedge core_clk) done_ev && alternate_sample_sel && use_b);
  c_irq : cover property (@(posedge core_clk) compare_irq && write_mode == WM_COMPARE_ONLY);
  c_hit_race : cover property (@(posedge core_clk) done_ev && match && reg_wr &&
                               reg_addr == REG_HIT_LOW);
endmodule

/* src/adsc_pkg.sv */
package adsc_pkg;
  // Register indices on the data-memory port
  localparam logic [5:0] REG_TIMING    = 6'h00;
  localparam logic [5:0] REG_THRESH    = 6'h01;
  localparam logic [5:0] REG_SAMPSEL   = 6'h02;
  localparam logic [5:0] REG_HIT_HIGH  = 6'h03;
  localparam logic [5:0] REG_HIT_LOW   = 6'h04;
  localparam logic [5:0] REG_SCAN_HIGH = 6'h05;
  localparam logic [5:0] BUF_BASE      = 6'h20;

  localparam logic [15:0] RST_TIMING    = 16'h0000;
  localparam logic [15:0] RST_THRESH    = 16'h0000;
  localparam logic [15:0] RST_SAMPSEL   = 16'h0000;
  localparam logic [15:0] RST_HIT       = 16'h0000;
  localparam logic [15:0] RST_SCAN_HIGH = 16'h0000;

  // Conversion timing register fields
  localparam int TM_SRC_BIT  = 15;
  localparam int TM_EXT_BIT  = 14;
  localparam int TM_AST_LSB  = 8;
  localparam int TM_DIV_LSB  = 0;
  // Writable bits: source, auto-sample time, divider (bit 14 status, bit 13 reserved)
  localparam logic [15:0] TM_WMASK = 16'h9fff;

  // Threshold/scan control fields
  localparam int TS_SCAN_BIT = 15;
  localparam int TS_BG_BIT   = 12;
  localparam int TS_INT_LSB  = 8;
  localparam int TS_WM_LSB   = 2;
  localparam int TS_CM_LSB   = 0;
  localparam logic [15:0] TS_WMASK = 16'hf30f;

  // Sample select fields
  localparam int SS_NB_LSB = 13;
  localparam int SS_PB_LSB = 8;
  localparam int SS_NA_LSB = 5;
  localparam int SS_PA_LSB = 0;

  localparam logic [15:0] HIT_HIGH_MASK  = 16'h0003;
  localparam logic [15:0] SCAN_HIGH_MASK = 16'h7c03;
  localparam int          SCAN_HIGH_OFS  = 16;

  localparam logic [7:0] DIV_MAX  = 8'h3f;
  localparam logic [1:0] PV_2X_4X = 2'b11;

  typedef enum logic [1:0] {WM_SAVE_ALL, WM_SAVE_MATCH, WM_COMPARE_ONLY, WM_RSVD} adsc_wm_e;
  typedef enum logic [1:0] {CM_LESS, CM_GREATER, CM_INSIDE, CM_OUTSIDE} adsc_cm_e;
endpackage

/* tb/adc_sample_scan_compare_control_test.sv */
module adc_sample_scan_compare_control_test
  import adsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic        reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        adc_on = 1'b0;
  logic        sample_enable_bit = 1'b0;
  logic        alternate_sample_sel = 1'b0;
  logic [1:0]  positive_ref_config = 2'b00;
  logic [15:0] scan_select_low = 16'h0000;
  logic        rc_tick = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic [15:0] reg_rdata;
  logic        conv_start, bandgap_enable, bandgap_x4, result_wr, compare_irq;
  logic [4:0]  pos_input_sel, result_addr, pos_seen, addr_seen;
  logic [2:0]  neg_input_sel, neg_seen;
  logic [11:0] result_data, data_seen;
  logic        ext_seen, bg_seen, wr_seen, irq_seen;
  logic [15:0] rv;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n_wait;

  always #50 core_clk = ~core_clk;

  adsc_ctrl #(.NCH(18)) dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_on(adc_on),
    .sample_enable_bit(sample_enable_bit), .alternate_sample_sel(alternate_sample_sel),
    .positive_ref_config(positive_ref_config), .scan_select_low(scan_select_low),
    .rc_tick(rc_tick), .conv_done(conv_done), .conv_result(conv_result),
    .conv_start(conv_start), .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
    .bandgap_enable(bandgap_enable), .bandgap_x4(bandgap_x4), .result_wr(result_wr),
    .result_addr(result_addr), .result_data(result_data), .compare_irq(compare_irq)
  );

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Extra idle cycle after each write keeps reg_wr from being set and cleared in one step
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    reg_addr = a;
    step();
    v = reg_rdata;
  endtask

  // One full sample and conversion; timing register stays addressed to watch the status bit
  task automatic convert(input logic [11:0] r);
    sample_enable_bit = 1'b1;
    reg_addr = REG_TIMING;
    step();
    step();
    pos_seen = pos_input_sel;
    neg_seen = neg_input_sel;
    bg_seen = bandgap_enable;
    sample_enable_bit = 1'b0;
    n_wait = 0;
    ext_seen = 1'b0;
    while (conv_start !== 1'b1 && n_wait < 40) begin
      step();
      n_wait++;
      ext_seen |= reg_rdata[TM_EXT_BIT];
    end
    step();
    conv_done = 1'b1;
    conv_result = r;
    step();
    wr_seen = result_wr;
    irq_seen = compare_irq;
    data_seen = result_data;
    addr_seen = result_addr;
    conv_done = 1'b0;
    step();
  endtask

  // Thresholds of channel 4 pair: low 0x100, high 0x200
  function automatic logic match_of(input logic [1:0] cm, input logic [11:0] r);
    case (cm)
      2'b00: return r < 12'h100;
      2'b01: return r > 12'h100;
      2'b10: return r >= 12'h100 && r <= 12'h200;
      default: return r < 12'h100 || r > 12'h200;
    endcase
  endfunction

  task automatic t_registers();
    logic [5:0]  ad[6] = '{REG_TIMING, REG_THRESH, REG_SAMPSEL, REG_HIT_HIGH, REG_HIT_LOW,
                          REG_SCAN_HIGH};
    logic [15:0] wv[6] = '{16'hdf3f, 16'hfffb, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
    logic [15:0] ev[6] = '{16'h9f3f, 16'hf30b, 16'hffff, 16'h0003, 16'hffff, 16'h7c03};
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], rv);
      chk("reset_value", 16'h0000, rv);
      wr(ad[i], wv[i]);
      rd(ad[i], rv);
      chk("readback", ev[i], rv);
      wr(ad[i], 16'h0000);
    end
  endtask

  task automatic t_threshold();
    wr(BUF_BASE + 6'h03, 16'h0abc);
    rd(BUF_BASE + 6'h03, rv);
    chk("thr_off_write", 16'h0abc, rv);
    adc_on = 1'b1;
    wr(BUF_BASE + 6'h03, 16'h0555);
    rd(BUF_BASE + 6'h03, rv);
    chk("thr_on_write", 16'h0abc, rv);
    adc_on = 1'b0;
  endtask

  task automatic t_alternate();
    logic [4:0] ep[4] = '{5'd5, 5'd9, 5'd5, 5'd5};
    logic [2:0] en[4] = '{3'd1, 3'd2, 3'd1, 3'd1};
    // Set B: neg 2, pos 9; set A: neg 1, pos 5
    wr(REG_SAMPSEL, 16'h4925);
    alternate_sample_sel = 1'b1;
    adc_on = 1'b1;
    for (int i = 0; i < 4; i++) begin
      // Fourth pass falls on set B's turn but uses set A with alternation off
      if (i == 3) alternate_sample_sel = 1'b0;
      convert(12'h123);
      chk("pos_sel", {11'h000, ep[i]}, {11'h000, pos_seen});
      chk("neg_sel", {13'h0000, en[i]}, {13'h0000, neg_seen});
    end
  endtask

  task automatic t_compare();
    logic [11:0] rs[3] = '{12'h080, 12'h100, 12'h300};
    logic        m;
    adc_on = 1'b0;
    wr(BUF_BASE + 6'h04, 16'h0100);
    wr(BUF_BASE + 6'h05, 16'h0200);
    wr(REG_SAMPSEL, 16'h0004);
    adc_on = 1'b1;
    // Write mode 3 is reserved and must store nothing
    for (int w = 1; w <= 3; w++) begin
      for (int c = 0; c < 4; c++) begin
        for (int i = 0; i < 3; i++) begin
          wr(REG_THRESH, 16'h0100 | 16'(w * 4 + c));
          wr(REG_HIT_LOW, 16'h0000);
          convert(rs[i]);
          m = match_of(2'(c), rs[i]);
          chk_bit("result_wr", (w == 1) ? m : 1'b0, wr_seen);
          if (w == 1 && m) chk("result_data", {4'h0, rs[i]}, {4'h0, data_seen});
          if (w == 1 && m) chk("result_addr", 16'h0004, {11'h000, addr_seen});
          if (w == 2) chk_bit("compare_irq", m, irq_seen);
          rd(REG_HIT_LOW, rv);
          chk("hit_low", {11'h000, m, 4'h0}, rv);
        end
      end
    end
    // Save-all mode: outside-window mode flags a written buffer, greater-than does not
    wr(REG_THRESH, 16'h0003);
    wr(REG_HIT_LOW, 16'h0000);
    convert(12'h180);
    rd(REG_HIT_LOW, rv);
    chk("hit_written", 16'h0010, rv);
    wr(REG_THRESH, 16'h0001);
    wr(REG_HIT_LOW, 16'h0000);
    convert(12'h080);
    rd(REG_HIT_LOW, rv);
    chk("hit_no_match", 16'h0000, rv);
    // Compare-only with scan interrupts off stays silent even on a match
    wr(REG_THRESH, 16'h0008);
    convert(12'h080);
    chk_bit("irq_int_off", 1'b0, irq_seen);
    chk_bit("wr_int_off", 1'b0, wr_seen);
  endtask

  task automatic t_sample_time();
    wr(REG_THRESH, 16'h0000);
    wr(REG_TIMING, 16'h0000);
    convert(12'h001);
    chk("ast0_wait", 16'h0001, 16'(n_wait));
    // Three periods of four cycles each, tick phase unknown
    wr(REG_TIMING, 16'h0303);
    convert(12'h001);
    chk_bit("ast3_wait", 1'b1, n_wait >= 9 && n_wait <= 14);
    chk_bit("ext_flag", 1'b1, ext_seen);
    rd(REG_TIMING, rv);
    chk("ext_flag_clear", 16'h0303, rv);
  endtask

  task automatic t_rc_clock();
    logic seen;
    wr(REG_TIMING, 16'h8200);
    sample_enable_bit = 1'b1;
    step();
    step();
    sample_enable_bit = 1'b0;
    seen = 1'b0;
    repeat (20) begin
      step();
      seen |= conv_start;
    end
    chk_bit("rc_no_tick", 1'b0, seen);
    repeat (2) begin
      rc_tick = 1'b1;
      step();
      rc_tick = 1'b0;
      repeat (3) begin
        step();
        seen |= conv_start;
      end
    end
    chk_bit("rc_ticked", 1'b1, seen);
    conv_done = 1'b1;
    step();
    conv_done = 1'b0;
    step();
    wr(REG_TIMING, 16'h0000);
  endtask

  task automatic t_bandgap();
    wr(REG_THRESH, 16'h1000);
    chk_bit("bg_idle", 1'b0, bandgap_enable);
    convert(12'h010);
    chk_bit("bg_active", 1'b1, bg_seen);
    wr(REG_THRESH, 16'h0000);
    convert(12'h010);
    chk_bit("bg_not_requested", 1'b0, bg_seen);
    positive_ref_config = 2'b11;
    step();
    step();
    chk_bit("bg_x4", 1'b1, bandgap_x4);
    positive_ref_config = 2'b10;
    step();
    step();
    chk_bit("bg_x2", 1'b0, bandgap_x4);
  endtask

  task automatic t_scan();
    scan_select_low = 16'h0004;
    wr(REG_SCAN_HIGH, 16'h0001);
    wr(REG_THRESH, 16'h8000);
    convert(12'h020);
    chk("scan_first", 16'h0002, {11'h000, pos_seen});
    convert(12'h020);
    chk("scan_second", 16'h0010, {11'h000, pos_seen});
    wr(REG_THRESH, 16'h0000);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_registers();
    t_threshold();
    t_alternate();
    t_compare();
    t_sample_time();
    t_rc_clock();
    t_bandgap();
    t_scan();
    finish_test();
  end
endmodule
